// file: common/qpio_defines.svh
// Overview of operation
// (R1) four 8-bit bidirectional ports, data latches at 12H, 14H, 16H, 18H
// (R2) port reads sample live pad level during the read, nothing is latched
// (R3) written output data stays in its latch until rewritten
// (R4) per-line direction bit: 1 input, 0 push-pull output, changeable any time
// (R5) read returns pad level for inputs, latch contents for outputs
// (R6) direction registers at 13H, 15H, 17H, 19H after each data latch
// (R7) after reset every line is an input, idling per pull-high option
// (R8) bit set, clear, complement read whole port, modify, write back
// (R9) every port A line can wake the device from power-down; the code wakes only on port A lines set as input
// (R10) per-port build-time pull-high option; without it inputs float
// (R11) port A bits 0,1,3 carry buzzer pair and divider; D, C share inputs
// (R12) buzzer option: port A bits 0,1 output buzzer pair, gated by data bit 0
// (R13) buzzer: bit0 high drives pair, low drives both low; bit0 input forces bit1 low
// (R14) alternate-function pins act as ordinary inputs when set to input
// (R15) divider option: port A bit 3 output passes divider if data 1, else low
// (R16) divider output toggles on each timer overflow, halving overflow rate
// (R17) PWM channels appear on port D bits 0-3 only if enabled and outputs
// (R18) port D bits 0-3 under PWM: data 1 passes waveform, data 0 drives low
// (R19) each PWM channel has one 8-bit duty register in data memory
// (R20) one build option picks 7+1 or 6+2 for all channels; hardware splits cycle
// (R21) PWM counts from the system clock with no prescaler
// (R22) software should set unused lines as outputs to avoid floating inputs
// (R23) 6+2: base bits 7:2, extra bits 1:0; sub-cycle i high base+1 if i<extra
// (R24) 7+1: base bits 7:1, extra bit 0; sub-cycle i high base+1 if i<extra
// (R25) full PWM cycle is 256 clocks, duty equals register value over 256
// (R26) each sub-cycle is high for its leading duty clocks, then low
`ifndef QPIO_DEFINES_SVH
`define QPIO_DEFINES_SVH

`define QPIO_ADDR_FIRST_PORT      8'h12
`define QPIO_ADDR_FIRST_DIR       8'h13
`define QPIO_ADDR_SECOND_PORT     8'h14
`define QPIO_ADDR_SECOND_DIR      8'h15
`define QPIO_ADDR_THIRD_PORT      8'h16
`define QPIO_ADDR_THIRD_DIR       8'h17
`define QPIO_ADDR_FOURTH_PORT     8'h18
`define QPIO_ADDR_FOURTH_DIR      8'h19
`define QPIO_ADDR_DUTY_ZERO       8'h1a
`define QPIO_ADDR_DUTY_ONE        8'h1b
`define QPIO_ADDR_DUTY_TWO        8'h1c
`define QPIO_ADDR_DUTY_THREE      8'h1d

`define QPIO_DIR_RESET            8'hff
`define QPIO_LATCH_RESET          8'h00
`define QPIO_DUTY_RESET           8'h00
`define QPIO_READ_UNMAPPED        8'h00

`define QPIO_BIT_BUZZ             0
`define QPIO_BIT_BUZZ_N           1
`define QPIO_BIT_DIVIDER          3
`define QPIO_PWM_CHANNELS         4
`define QPIO_PWM_CYCLE            256

`endif

// file: common/qpio_pkg.sv
package qpio_pkg;

    // one data memory access from the core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } qpio_bus_s;

    // build-time configuration options
    typedef struct packed {
        logic       buzzer_en;
        logic       divider_en;
        logic       pwm_en;
        logic       pwm_mode_62;
        logic [3:0] pull_en;
    } qpio_opt_s;

    typedef logic [3:0][7:0] qpio_bank_t;

endpackage

// file: sim/qpio_pad_model.sv
`timescale 1ns/1ps

module qpio_pad_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] pad_out_i,
    input  wire logic [31:0] pad_oe_i,
    input  wire logic [31:0] pull_en_i,
    input  wire logic [31:0] ext_val_i,
    input  wire logic [31:0] ext_en_i,
    output logic [31:0]      pad_o
);
    // ********************************
    // board side of the pads
    // ********************************
    logic [31:0] wander = 32'h0;

    // an undriven line without pull-up wanders each cycle
    always_ff @(posedge clk_i) begin
        wander <= ~wander;
    end

    assign pad_o = (pad_oe_i & pad_out_i)
                 | (~pad_oe_i & ext_en_i & ext_val_i)
                 | (~pad_oe_i & ~ext_en_i & pull_en_i)
                 | (~pad_oe_i & ~ext_en_i & ~pull_en_i & wander);
endmodule

// file: sim/qpio_top_test.sv
`timescale 1ns/1ps

module qpio_top_test;
    import qpio_pkg::*;

    logic        clk_i     = 1'b0;
    logic        reset_n_i = 1'b0;
    qpio_bus_s   bus       = '0;
    qpio_opt_s   opt       = '0;
    logic        buzzer    = 1'b0;
    logic        tmr_ovf   = 1'b0;
    logic [31:0] ext_val   = 32'h0;
    logic [31:0] ext_en    = 32'h0;
    logic [7:0]  rd_data;
    logic [31:0] pad_in;
    logic [31:0] pad_out;
    logic [31:0] pad_oe;
    logic [31:0] pull_en;
    logic        wake;
    int          miscompares = 0;
    int          compares    = 0;

    always #5 clk_i = ~clk_i;

    qpio_top qpio_top_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus), .rd_data_o(rd_data),
        .opt_i(opt), .buzzer_i(buzzer), .tmr_ovf_i(tmr_ovf), .pad_in_i(pad_in), .pad_out_o(pad_out),
        .pad_oe_o(pad_oe), .pull_en_o(pull_en), .wake_o(wake));

    qpio_pad_model qpio_pad_model_i (.clk_i(clk_i), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
        .pull_en_i(pull_en), .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_o(pad_in));

    // ********************************
    // shared tasks
    // ********************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic start(input logic bz, input logic dv, input logic pw, input logic m62);
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        opt       <= '{buzzer_en: bz, divider_en: dv, pwm_en: pw, pwm_mode_62: m62, pull_en: 4'b0101};
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk_i);
        bus <= '0;
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_i);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk_i);
        bus <= '0;
        tick(1);
        data = rd_data;
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic t_ports();
        logic [7:0] got;
        logic [7:0] lat;
        start(1'b0, 1'b0, 1'b0, 1'b0);
        tick(2);
        check("pull", pull_en, 32'h00ff00ff);
        check("oe reset", pad_oe, 32'h0);
        @(posedge clk_i);
        ext_en  <= 32'hffffffff;
        ext_val <= 32'hc3c3c3c3;
        for (int p = 0; p < 4; p++) begin
            rd(8'h13 + 8'(2 * p), got);
            check("dir reset", got, 8'hff);
            lat = 8'h5a ^ 8'(p);
            wr(8'h12 + 8'(2 * p), lat);
            wr(8'h13 + 8'(2 * p), 8'h0f);
            rd(8'h13 + 8'(2 * p), got);
            check("dir", got, 8'h0f);
            rd(8'h12 + 8'(2 * p), got);
            check("mixed read", got, 8'h03 | (lat & 8'hf0));
            check("pad out", pad_out[8*p +: 4], lat[3:0]);
            check("pad oe", pad_oe[8*p +: 8], 8'hf0);
        end
        @(posedge clk_i);
        ext_val <= 32'h3c3c3c3c;
        rd(8'h18, got);
        check("live read", got, 8'h0c | (lat & 8'hf0));
        wr(8'h18, got | 8'h40);
        wr(8'h19, 8'h00);
        tick(2);
        check("modify write", pad_out[31:24], got | 8'h40);
        rd(8'h20, got);
        check("unmapped", got, 8'h00);
        $display("ports done");
    endtask

    task automatic t_buzzer();
        logic [7:0] got;
        start(1'b1, 1'b0, 1'b0, 1'b0);
        wr(8'h12, 8'h01);
        wr(8'h13, 8'hfc);
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_i);
            buzzer <= s[0];
            tick(2);
            check("buzzer pair", pad_out[1:0], {~s[0], s[0]});
        end
        wr(8'h12, 8'h00);
        tick(2);
        check("buzzer off", pad_out[1:0], 2'b00);
        wr(8'h12, 8'h01);
        wr(8'h13, 8'hfd);
        tick(2);
        check("buzzer half", pad_out[1], 1'b0);
        rd(8'h12, got);
        check("alt as input", got, 8'h3c);
        $display("buzzer done");
    endtask

    task automatic t_divider();
        start(1'b0, 1'b1, 1'b0, 1'b0);
        wr(8'h12, 8'h08);
        wr(8'h13, 8'hf7);
        for (int k = 1; k <= 3; k++) begin
            @(posedge clk_i);
            tmr_ovf <= 1'b1;
            @(posedge clk_i);
            tmr_ovf <= 1'b0;
            tick(3);
            check("divider", pad_out[3], k[0]);
        end
        wr(8'h12, 8'h00);
        tick(2);
        check("divider gated", pad_out[3], 1'b0);
        $display("divider done");
    endtask

    task automatic t_pwm(input logic m62, input int rises_exp, input int run_exp);
        logic [511:0] w;
        logic [1:0]   quiet = 2'b00;
        int           high  = 0;
        int           rises = 0;
        int           run   = 0;
        int           best  = 0;
        start(1'b0, 1'b0, 1'b1, m62);
        wr(8'h19, 8'hf8);
        wr(8'h18, 8'h0e);
        for (int c = 0; c < 4; c++) begin
            wr(8'h1a + 8'(c), 8'h67);
        end
        tick(4);
        for (int t = 0; t < 512; t++) begin
            w[t] = pad_out[25];
            quiet = quiet | {pad_out[24], pad_oe[27]};
            tick(1);
        end
        for (int t = 1; t < 512; t++) begin
            run = w[t] ? run + 1 : 0;
            best = (run > best) ? run : best;
            if (t <= 256) begin
                high += w[t];
                rises += w[t] & ~w[t-1];
            end
        end
        check("pwm duty", high, 103);
        check("pwm subcycles", rises, rises_exp);
        check("pwm longest", best, run_exp);
        check("pwm gated", quiet, 2'b00);
        $display("pwm done");
    endtask

    task automatic t_wake();
        logic [7:0] n = 8'h00;
        start(1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge clk_i);
        ext_val <= 32'hffffffff;
        for (int t = 0; t < 4; t++) begin
            tick(1);
            n = n + 8'(wake);
        end
        check("wake after reset", n, 8'h00);
        n = 8'h00;
        @(posedge clk_i);
        ext_val <= 32'hfffffbfb;
        for (int t = 0; t < 4; t++) begin
            tick(1);
            n = n + 8'(wake);
        end
        check("wake pulses", n, 8'h01);
        $display("wake done");
    endtask

    initial begin
        #900us;
        miscompares++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        report_and_stop();
    end

    initial begin
        t_ports();
        t_buzzer();
        t_divider();
        t_pwm(1'b1, 4, 26);
        t_pwm(1'b0, 2, 52);
        t_wake();
        report_and_stop();
    end
endmodule

// file: verilog/qpio_top.sv
`timescale 1ns/1ps
`include "qpio_defines.svh"

module qpio_top (
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    input  wire qpio_pkg::qpio_bus_s bus_i,
    output logic [7:0]               rd_data_o,
    input  wire qpio_pkg::qpio_opt_s opt_i,
    input  wire logic                buzzer_i,
    input  wire logic                tmr_ovf_i,
    input  wire logic [31:0]         pad_in_i,
    output logic [31:0]              pad_out_o,
    output logic [31:0]              pad_oe_o,
    output logic [31:0]              pull_en_o,
    output logic                     wake_o
);
    import qpio_pkg::*;

    qpio_bank_t  latch;
    qpio_bank_t  dir;
    qpio_bank_t  duty;
    qpio_bank_t  port_view;
    logic [7:0]  next_rd_data;
    logic [7:0]  pwm_cnt;
    wire  [3:0]  pwm_wave;
    logic        freq_divider_out;
    logic [7:0]  first_port_prev;
    logic [31:0] next_pad_out;
    logic [31:0] next_pull;
    logic [31:0] dir_flat;

    assign dir_flat = dir;

    // ****************************************
    // register writes
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            latch <= {4{`QPIO_LATCH_RESET}};
            dir   <= {4{`QPIO_DIR_RESET}}; // see (R7)
            duty  <= {4{`QPIO_DUTY_RESET}};
        end else if (bus_i.wr) begin
            // latches change only on their own write; see (R3) (R8)
            if (bus_i.addr == `QPIO_ADDR_FIRST_PORT) begin // see (R1)
                latch[0] <= bus_i.wdata;
            end else if (bus_i.addr == `QPIO_ADDR_FIRST_DIR) begin // see (R6) (R4)
                dir[0] <= bus_i.wdata;
            end else if (bus_i.addr == `QPIO_ADDR_SECOND_PORT) begin
                latch[1] <= bus_i.wdata;
            end else if (bus_i.addr == `QPIO_ADDR_SECOND_DIR) begin
                dir[1] <= bus_i.wdata;
            end else if (bus_i.addr == `QPIO_ADDR_THIRD_PORT) begin
                latch[2] <= bus_i.wdata;
            end else if (bus_i.addr == `QPIO_ADDR_THIRD_DIR) begin
                dir[2] <= bus_i.wdata;
            end else if (bus_i.addr == `QPIO_ADDR_FOURTH_PORT) begin
                latch[3] <= bus_i.wdata;
            end else if (bus_i.addr == `QPIO_ADDR_FOURTH_DIR) begin
                dir[3] <= bus_i.wdata;
            end else if (bus_i.addr == `QPIO_ADDR_DUTY_ZERO) begin // see (R19)
                duty[0] <= bus_i.wdata;
            end else if (bus_i.addr == `QPIO_ADDR_DUTY_ONE) begin
                duty[1] <= bus_i.wdata;
            end else if (bus_i.addr == `QPIO_ADDR_DUTY_TWO) begin
                duty[2] <= bus_i.wdata;
            end else if (bus_i.addr == `QPIO_ADDR_DUTY_THREE) begin
                duty[3] <= bus_i.wdata;
            end
        end
    end

    // ****************************************
    // register reads
    // ****************************************
    // inputs show the live pad, outputs their latch; see (R2) (R5) (R14)
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            port_view[p] = (dir[p] & pad_in_i[p*8 +: 8]) | (~dir[p] & latch[p]);
        end
    end

    always_comb begin
        if (bus_i.addr == `QPIO_ADDR_FIRST_PORT) begin
            next_rd_data = port_view[0];
        end else if (bus_i.addr == `QPIO_ADDR_FIRST_DIR) begin
            next_rd_data = dir[0];
        end else if (bus_i.addr == `QPIO_ADDR_SECOND_PORT) begin
            next_rd_data = port_view[1];
        end else if (bus_i.addr == `QPIO_ADDR_SECOND_DIR) begin
            next_rd_data = dir[1];
        end else if (bus_i.addr == `QPIO_ADDR_THIRD_PORT) begin
            next_rd_data = port_view[2];
        end else if (bus_i.addr == `QPIO_ADDR_THIRD_DIR) begin
            next_rd_data = dir[2];
        end else if (bus_i.addr == `QPIO_ADDR_FOURTH_PORT) begin
            next_rd_data = port_view[3];
        end else if (bus_i.addr == `QPIO_ADDR_FOURTH_DIR) begin
            next_rd_data = dir[3];
        end else if (bus_i.addr == `QPIO_ADDR_DUTY_ZERO) begin
            next_rd_data = duty[0];
        end else if (bus_i.addr == `QPIO_ADDR_DUTY_ONE) begin
            next_rd_data = duty[1];
        end else if (bus_i.addr == `QPIO_ADDR_DUTY_TWO) begin
            next_rd_data = duty[2];
        end else if (bus_i.addr == `QPIO_ADDR_DUTY_THREE) begin
            next_rd_data = duty[3];
        end else begin
            next_rd_data = `QPIO_READ_UNMAPPED;
        end
    end

    // pad level is sampled on the read cycle itself
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rd_data_o <= `QPIO_READ_UNMAPPED;
        end else if (bus_i.rd) begin
            rd_data_o <= next_rd_data; // see (R2)
        end
    end

    // ****************************************
    // pwm generator
    // ****************************************
    // free-running cycle counter on the system clock
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pwm_cnt <= '0;
        end else begin
            pwm_cnt <= pwm_cnt + 8'h01; // see (R21) (R25)
        end
    end

    for (genvar g = 0; g < `QPIO_PWM_CHANNELS; g++) begin : g_pwm
        logic [7:0] pos;
        logic [7:0] lim;
        always_comb begin
            if (opt_i.pwm_mode_62) begin // see (R20)
                // four 64-clock sub-cycles; see (R23)
                pos = {2'b00, pwm_cnt[5:0]};
                lim = {2'b00, duty[g][7:2]} + {7'h00, (pwm_cnt[7:6] < duty[g][1:0])};
            end else begin
                // two 128-clock sub-cycles; see (R24)
                pos = {1'b0, pwm_cnt[6:0]};
                lim = {1'b0, duty[g][7:1]} + {7'h00, (pwm_cnt[7] < duty[g][0])};
            end
        end
        assign pwm_wave[g] = pos < lim; // see (R26)
    end

    // ****************************************
    // divider output
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            freq_divider_out <= 1'b0;
        end else if (tmr_ovf_i) begin
            freq_divider_out <= ~freq_divider_out; // see (R16)
        end
    end

    // ****************************************
    // pad drive with alternate functions
    // ****************************************
    always_comb begin
        next_pad_out = latch;
        if (opt_i.buzzer_en) begin // see (R11) (R12) (R13)
            next_pad_out[`QPIO_BIT_BUZZ]   = latch[0][`QPIO_BIT_BUZZ] & buzzer_i;
            next_pad_out[`QPIO_BIT_BUZZ_N] = latch[0][`QPIO_BIT_BUZZ] & ~dir[0][`QPIO_BIT_BUZZ] & ~buzzer_i;
        end
        if (opt_i.divider_en) begin // see (R15)
            next_pad_out[`QPIO_BIT_DIVIDER] = latch[0][`QPIO_BIT_DIVIDER] & freq_divider_out;
        end
        if (opt_i.pwm_en) begin // see (R17) (R18)
            next_pad_out[24 +: 4] = latch[3][3:0] & pwm_wave;
        end
        for (int p = 0; p < 4; p++) begin
            next_pull[p*8 +: 8] = {8{opt_i.pull_en[p]}} & dir[p]; // see (R10)
        end
    end

    // oe low makes every line a plain input; see (R4) (R7) (R14)
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pad_out_o <= '0;
            pad_oe_o  <= '0;
            pull_en_o <= '0;
        end else begin
            pad_out_o <= next_pad_out;
            pad_oe_o  <= ~dir_flat;
            pull_en_o <= next_pull;
        end
    end

    // ****************************************
    // port a wake-up
    // ****************************************
    // falling edge on any port a input line raises a one-cycle wake pulse
    // history resets low so a line sitting low through reset gives no false wake
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            first_port_prev <= '0;
            wake_o          <= 1'b0;
        end else begin
            first_port_prev <= pad_in_i[7:0];
            wake_o          <= |(dir[0] & first_port_prev & ~pad_in_i[7:0]); // see (R9)
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_reset_release;
        !reset_n_i ##1 reset_n_i;
    endsequence

    sequence s_cycle_start;
        pwm_cnt == 8'h00;
    endsequence

    property p_reset_inputs;
        @(posedge clk_i) s_reset_release |-> (pad_oe_o == '0) && (dir_flat == '1);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("lines not inputs after reset"); // see (R7)

    property p_read_pad;
        @(posedge clk_i) disable iff (!reset_n_i)
            bus_i.rd && bus_i.addr == `QPIO_ADDR_FIRST_PORT && dir[0] == 8'hff
            |=> rd_data_o == $past(pad_in_i[7:0]);
    endproperty
    a_read_pad: assert property (p_read_pad) else $error("input read not live pad"); // see (R2)

    property p_read_latch;
        @(posedge clk_i) disable iff (!reset_n_i)
            bus_i.rd && bus_i.addr == `QPIO_ADDR_SECOND_PORT && dir[1] == 8'h00
            |=> rd_data_o == $past(latch[1]);
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("output read not latch"); // see (R5)

    property p_latch_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
            !(bus_i.wr && bus_i.addr == `QPIO_ADDR_THIRD_PORT) |=> $stable(latch[2]);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed without write"); // see (R3)

    property p_oe_follows_dir;
        @(posedge clk_i) disable iff (!reset_n_i)
            bus_i.wr && bus_i.addr == `QPIO_ADDR_FOURTH_DIR
            |=> ##1 pad_oe_o[31:24] == ~$past(bus_i.wdata, 2);
    endproperty
    a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("oe not from direction"); // see (R4)

    property p_pwm_period;
        @(posedge clk_i) disable iff (!reset_n_i)
            s_cycle_start |-> ##256 s_cycle_start;
    endproperty
    a_pwm_period: assert property (p_pwm_period) else $error("pwm cycle not 256 clocks"); // see (R25)

    property p_pwm_off_low;
        @(posedge clk_i) disable iff (!reset_n_i)
            opt_i.pwm_en && !latch[3][0] |=> !pad_out_o[24];
    endproperty
    a_pwm_off_low: assert property (p_pwm_off_low) else $error("pwm pin not held low"); // see (R18)

    property p_buzz_n_low;
        @(posedge clk_i) disable iff (!reset_n_i)
            opt_i.buzzer_en && dir[0][0] |=> !pad_out_o[1];
    endproperty
    a_buzz_n_low: assert property (p_buzz_n_low) else $error("inverted buzzer not low"); // see (R13)

    property p_divider_toggle;
        @(posedge clk_i) disable iff (!reset_n_i)
            tmr_ovf_i |=> freq_divider_out != $past(freq_divider_out);
    endproperty
    a_divider_toggle: assert property (p_divider_toggle) else $error("divider did not toggle"); // see (R16)

    property p_duty_62_first;
        @(posedge clk_i) disable iff (!reset_n_i)
            opt_i.pwm_mode_62 && pwm_cnt[5:0] == 6'h00 && duty[0] >= 8'h04 |-> pwm_wave[0];
    endproperty
    a_duty_62_first: assert property (p_duty_62_first) else $error("sub-cycle not high at start"); // see (R23) (R26)

    property p_read_dir;
        @(posedge clk_i) disable iff (!reset_n_i)
            bus_i.rd && bus_i.addr == `QPIO_ADDR_FIRST_DIR
            |=> rd_data_o == $past(dir[0]);
    endproperty
    a_read_dir: assert property (p_read_dir) else $error("direction read wrong"); // see (R6)

    property p_read_unmapped;
        @(posedge clk_i) disable iff (!reset_n_i)
            bus_i.rd && bus_i.addr > `QPIO_ADDR_DUTY_THREE
            |=> rd_data_o == `QPIO_READ_UNMAPPED;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero"); // see (R1)

    property p_rd_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
            !bus_i.rd
            |=> $stable(rd_data_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read"); // see (R2)

    property p_dir_write;
        @(posedge clk_i) disable iff (!reset_n_i)
            bus_i.wr && bus_i.addr == `QPIO_ADDR_SECOND_DIR
            |=> dir[1] == $past(bus_i.wdata);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction not written"); // see (R4)

    property p_latch_write;
        @(posedge clk_i) disable iff (!reset_n_i)
            bus_i.wr && bus_i.addr == `QPIO_ADDR_FIRST_PORT
            |=> latch[0] == $past(bus_i.wdata);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch not written"); // see (R3)

    property p_pull_off;
        @(posedge clk_i) disable iff (!reset_n_i)
            !opt_i.pull_en[1]
            |=> pull_en_o[15:8] == 8'h00;
    endproperty
    a_pull_off: assert property (p_pull_off) else $error("pull-up without option"); // see (R10)

    property p_pull_out;
        @(posedge clk_i) disable iff (!reset_n_i)
            dir[2][4] == 1'b0
            |=> !pull_en_o[20];
    endproperty
    a_pull_out: assert property (p_pull_out) else $error("pull-up on output line"); // see (R10)

    property p_div_gated;
        @(posedge clk_i) disable iff (!reset_n_i)
            opt_i.divider_en && !latch[0][3]
            |=> !pad_out_o[3];
    endproperty
    a_div_gated: assert property (p_div_gated) else $error("divider pin not held low"); // see (R15)

    property p_buzz_off;
        @(posedge clk_i) disable iff (!reset_n_i)
            opt_i.buzzer_en && !latch[0][0]
            |=> pad_out_o[1:0] == 2'b00;
    endproperty
    a_buzz_off: assert property (p_buzz_off) else $error("buzzer pair not low"); // see (R13)

    sequence s_line_fell;
        $past(reset_n_i) && dir[0][2] && $fell(pad_in_i[2]);
    endsequence

    property p_wake_cause;
        @(posedge clk_i) disable iff (!reset_n_i)
            s_line_fell
            |=> wake_o;
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("falling line gave no wake"); // see (R9)

    property p_pwm_zero;
        @(posedge clk_i) disable iff (!reset_n_i)
            duty[0] == 8'h00
            |-> !pwm_wave[0];
    endproperty
    a_pwm_zero: assert property (p_pwm_zero) else $error("zero duty not low"); // see (R26)

    property p_duty_62_last;
        @(posedge clk_i) disable iff (!reset_n_i)
            opt_i.pwm_mode_62 && pwm_cnt[5:0] == 6'h3f && duty[1][7:2] != 6'h3f
            |-> !pwm_wave[1];
    endproperty
    a_duty_62_last: assert property (p_duty_62_last) else $error("sub-cycle not low at end"); // see (R23)

    property p_duty_71_first;
        @(posedge clk_i) disable iff (!reset_n_i)
            !opt_i.pwm_mode_62 && pwm_cnt[6:0] == 7'h00 && duty[0] >= 8'h02
            |-> pwm_wave[0];
    endproperty
    a_duty_71_first: assert property (p_duty_71_first) else $error("half cycle not high at start"); // see (R24)

    property p_pwm_pass;
        @(posedge clk_i) disable iff (!reset_n_i)
            opt_i.pwm_en && latch[3][1]
            |=> pad_out_o[25] == $past(pwm_wave[1]);
    endproperty
    a_pwm_pass: assert property (p_pwm_pass) else $error("pwm wave not passed"); // see (R18)

endmodule
